// *** pkg/line_state_pkg.sv ***
`default_nettype none
package line_state_pkg;
   // ***********************************************
   // register map
   // ***********************************************
   localparam logic [7:0] injection_symbol_second_addr = 8'h07;
   localparam logic [7:0] receive_line_state_addr = 8'h08;
   localparam logic [7:0] injection_symbol_second_rst = 8'h00;
   localparam int sym_w = 5;
   localparam int code_w = 3;
   localparam int unknown_pos = 3;
   // ***********************************************
   // line state codes
   // ***********************************************
   localparam logic [2:0] active_state = 3'h0;
   localparam logic [2:0] idle_state = 3'h1;
   localparam logic [2:0] no_signal_state = 3'h2;
   localparam logic [2:0] master_state = 3'h4;
   localparam logic [2:0] halt_state = 3'h5;
   localparam logic [2:0] quiet_state = 3'h6;
   localparam logic [2:0] noise_state = 3'h7;
   // ***********************************************
   // received pair patterns and counts
   // ***********************************************
   localparam logic [9:0] pair_start = 10'h311;
   localparam logic [9:0] pair_idle = 10'h3ff;
   localparam logic [9:0] pair_halt_quiet = 10'h080;
   localparam logic [9:0] pair_halt = 10'h084;
   localparam logic [9:0] pair_quiet = 10'h000;
   localparam logic [4:0] idle_min = 5'h02;
   localparam logic [4:0] line_min = 5'h08;
   localparam logic [4:0] noise_min = 5'h10;
   // injection modes
   localparam logic [1:0] inj_off = 2'h0;
   localparam logic [1:0] inj_one_shot = 2'h1;
   localparam logic [1:0] inj_periodic = 2'h2;
   localparam logic [1:0] inj_continuous = 2'h3;
endpackage
`default_nettype wire

// *** pkg/pair_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// carries received pair classification from the detector to the register bank
interface pair_if;
   logic valid; // one received pair this cycle
   logic [2:0] kind; // which line-state pattern the pair matches
   logic known; // pair matches a line-state pattern
   modport src (output valid, output kind, output known);
   modport dst (input valid, input kind, input known);
endinterface
`default_nettype wire

// *** tb/host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ***********************************
// control bus host
// ***********************************
module host_model (
   // clock
   input wire logic clock_i,
   // control bus
   output logic bus_wr_o,
   output logic bus_rd_o,
   output logic [7:0] bus_addr_o,
   output logic [7:0] bus_wdata_o,
   input wire logic [7:0] bus_rdata_i
);
   // bus idle at time zero
   initial begin
      bus_wr_o = 1'b0;
      bus_rd_o = 1'b0;
      bus_addr_o = 8'h00;
      bus_wdata_o = 8'h00;
   end
   // one write strobe; data inverted after so a stale value is never read as valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock_i);
      bus_addr_o = a;
      bus_wdata_o = d;
      bus_wr_o = 1'b1;
      @(negedge clock_i);
      bus_wr_o = 1'b0;
      bus_wdata_o = ~d;
   endtask
   // read strobe; registered data is settled by the next falling edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clock_i);
      bus_addr_o = a;
      bus_rd_o = 1'b1;
      @(negedge clock_i);
      bus_rd_o = 1'b0;
      d = bus_rdata_i;
   endtask
endmodule
`default_nettype wire

// *** tb/line_state_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
// ***********************************
// bus and line state checker
// ***********************************
module line_state_monitor import line_state_pkg::*; (
   // watched ports
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic bus_wr_i,
   input wire logic bus_rd_i,
   input wire logic [7:0] bus_addr_i,
   input wire logic [7:0] bus_rdata_o,
   input wire logic write_reject_flag_o,
   input wire logic pair_valid_i,
   input wire logic [9:0] pair_i,
   input wire logic signal_detect_in_i,
   input wire logic clock_detect_i,
   input wire logic loopback_i,
   input wire logic stop_mode_i,
   input wire logic [1:0] inj_mode_i,
   input wire logic [4:0] injection_symbol_first_i,
   input wire logic tx_pair_slot_i,
   input wire logic tx_data_pair_i,
   input wire logic inj_active_o,
   input wire logic [9:0] inj_pair_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   // start delimiter seen while the line is up
   sequence s_start_rx;
      pair_valid_i && pair_i == pair_start && (signal_detect_in_i || loopback_i)
         && clock_detect_i && !stop_mode_i;
   endsequence
   // quiet status read with no pair in flight
   sequence s_status_rd;
      bus_rd_i && bus_addr_i == receive_line_state_addr && !pair_valid_i;
   endsequence
   a_wr08_rejected: assert property (bus_wr_i && bus_addr_i == receive_line_state_addr |=> write_reject_flag_o) else $error("reject pulse missing");
   a_reject_cause: assert property (write_reject_flag_o |-> $past(bus_wr_i && bus_addr_i == receive_line_state_addr)) else $error("reject pulse without cause");
   a_rdata_held: assert property (!bus_rd_i |=> $stable(bus_rdata_o)) else $error("read data moved");
   a_start_active: assert property (s_start_rx ##[1:3] s_status_rd |=> bus_rdata_o == 8'h00) else $error("start pair not active");
   a_lost_clock: assert property (bus_rd_i && bus_addr_i == receive_line_state_addr && !clock_detect_i && $past(!clock_detect_i) && !stop_mode_i |=> bus_rdata_o == 8'h02) else $error("no signal code missing");
   a_cont_inject: assert property (inj_mode_i == inj_continuous && tx_pair_slot_i && tx_data_pair_i |=> inj_active_o) else $error("data pair not replaced");
   a_no_slot: assert property (!tx_pair_slot_i |=> !inj_active_o) else $error("injection without slot");
   a_pair_first: assert property (inj_active_o |-> inj_pair_o[9:5] == $past(injection_symbol_first_i)) else $error("first symbol misplaced");
   a_sym_upper: assert property (bus_rd_i && bus_addr_i == injection_symbol_second_addr |=> bus_rdata_o[7:5] == 3'h0) else $error("upper bits not zero");
endmodule
bind line_state_and_injection_regs line_state_monitor line_state_monitor_i (.clock_i, .sys_rst_i,
   .bus_wr_i, .bus_rd_i, .bus_addr_i, .bus_rdata_o, .write_reject_flag_o, .pair_valid_i, .pair_i,
   .signal_detect_in_i, .clock_detect_i, .loopback_i, .stop_mode_i, .inj_mode_i,
   .injection_symbol_first_i, .tx_pair_slot_i, .tx_data_pair_i, .inj_active_o, .inj_pair_o);
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// ***********************************
// register bank testbench
// ***********************************
module tb_top import line_state_pkg::*;;
   logic clock_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic bus_wr_i, bus_rd_i;
   logic [7:0] bus_addr_i, bus_wdata_i;
   wire logic [7:0] bus_rdata_o;
   wire logic write_reject_flag_o, inj_active_o;
   wire logic [9:0] inj_pair_o;
   logic pair_valid_i = 1'b0, noise_event_i = 1'b0, signal_detect_in_i = 1'b1;
   logic clock_detect_i = 1'b1, loopback_i = 1'b0, stop_mode_i = 1'b0, stop_set_bit0_i = 1'b0;
   logic [9:0] pair_i = 10'h000;
   logic [1:0] inj_mode_i = inj_off;
   logic [7:0] inj_threshold_i = 8'h03;
   logic [4:0] injection_symbol_first_i = 5'h13;
   logic tx_pair_slot_i = 1'b0, tx_start_pair_i = 1'b0, tx_data_pair_i = 1'b0;
   int n_errors = 0;
   int check_count = 0;
   // long runs of like pairs and the code each one reaches
   logic [9:0] pats [3] = '{pair_halt_quiet, pair_halt, pair_quiet};
   logic [2:0] codes [3] = '{master_state, halt_state, quiet_state};
   always #5 clock_i = ~clock_i;
   host_model host_model_i (.clock_i(clock_i), .bus_wr_o(bus_wr_i), .bus_rd_o(bus_rd_i),
      .bus_addr_o(bus_addr_i), .bus_wdata_o(bus_wdata_i), .bus_rdata_i(bus_rdata_o));
   line_state_and_injection_regs line_state_and_injection_regs_i (.clock_i, .sys_rst_i,
      .bus_wr_i, .bus_rd_i, .bus_addr_i, .bus_wdata_i, .bus_rdata_o, .write_reject_flag_o,
      .pair_valid_i, .pair_i, .noise_event_i, .signal_detect_in_i, .clock_detect_i, .loopback_i,
      .stop_mode_i, .stop_set_bit0_i, .inj_mode_i, .inj_threshold_i, .injection_symbol_first_i,
      .tx_pair_slot_i, .tx_start_pair_i, .tx_data_pair_i, .inj_active_o, .inj_pair_o);
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic st(input logic [7:0] e);
      logic [7:0] d;
      host_model_i.rd(receive_line_state_addr, d);
      chk({2'h0, d}, {2'h0, e});
   endtask
   // back-to-back pairs, or noise pulses, held for n edges
   task automatic send(input logic [9:0] p, input int n, input logic nz);
      @(negedge clock_i);
      pair_i = p;
      pair_valid_i = !nz;
      noise_event_i = nz;
      repeat (n) @(negedge clock_i);
      pair_valid_i = 1'b0;
      noise_event_i = 1'b0;
      pair_i = ~p;
   endtask
   task automatic slot(input logic s, input logic dt, output logic a);
      @(negedge clock_i);
      tx_pair_slot_i = 1'b1;
      tx_start_pair_i = s;
      tx_data_pair_i = dt;
      @(negedge clock_i);
      a = inj_active_o;
      tx_pair_slot_i = 1'b0;
   endtask
   task automatic summarize;
      if (n_errors == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // watchdog well past the under two hundred cycles the tests need
   initial begin
      #200000;
      n_errors++;
      summarize();
   end
   initial begin
      logic [7:0] d;
      logic a;
      logic [4:0] v;
      logic [2:0] prev;
      int cnt;
      repeat (10) @(negedge clock_i);
      sys_rst_i = 1'b0;
      st(8'h0A);
      host_model_i.rd(injection_symbol_second_addr, d);
      chk({2'h0, d}, 10'h000);
      host_model_i.wr(injection_symbol_second_addr, 8'hEC);
      host_model_i.rd(injection_symbol_second_addr, d);
      chk({2'h0, d}, 10'h00C);
      host_model_i.wr(receive_line_state_addr, 8'h55);
      chk({9'h000, write_reject_flag_o}, 10'h001);
      st(8'h0A);
      send(pair_start, 1, 1'b0);
      st(8'h00);
      send(pair_idle, 1, 1'b0);
      st(8'h08);
      send(pair_idle, 2, 1'b0);
      st(8'h01);
      prev = idle_state;
      for (int i = 0; i < 3; i++) begin
         send(pats[i], 7, 1'b0);
         st({5'h01, prev});
         send(pats[i], 1, 1'b0);
         st({5'h00, codes[i]});
         prev = codes[i];
      end
      send(10'h000, 15, 1'b1);
      st({5'h00, quiet_state});
      send(10'h000, 1, 1'b1);
      st(8'h07);
      signal_detect_in_i = 1'b0;
      st(8'h02);
      loopback_i = 1'b1;
      send(pair_start, 1, 1'b0);
      st(8'h00);
      clock_detect_i = 1'b0;
      st(8'h02);
      clock_detect_i = 1'b1;
      stop_mode_i = 1'b1;
      st(8'h02);
      stop_set_bit0_i = 1'b1;
      st(8'h03);
      inj_mode_i = inj_continuous;
      slot(1'b0, 1'b1, a);
      chk({9'h000, a}, 10'h001);
      chk(inj_pair_o, {injection_symbol_first_i, 5'h0C});
      slot(1'b0, 1'b0, a);
      chk({9'h000, a}, 10'h000);
      inj_mode_i = inj_periodic;
      cnt = 0;
      repeat (6) begin
         slot(1'b0, 1'b1, a);
         cnt += int'(a);
      end
      chk(10'(cnt), 10'h002);
      inj_threshold_i = 8'h02;
      inj_mode_i = inj_one_shot;
      for (int i = 0; i < 5; i++) begin
         slot(i == 0, 1'b1, a);
         v[i] = a;
      end
      chk({5'h00, v}, 10'h004);
      summarize();
   end
endmodule
`default_nettype wire

// *** verilog/line_state_and_injection_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - second injection symbol register at 07h
// - symbol lsb leaves last on medium
// - one-shot injects n bytes after start
// - periodic injects every n-th pair if it is a data pair
// - continuous replaces every data pair
// - upper three bits reset zero, inert
// - new line state replaces old code
// - reset forces unknown flag set
// - write to 08h discarded, reject flagged
// - start pair gives active code
// - two idle pairs give idle code
// - lost signal or clock gives code
// - loopback ignores signal detect
// - stop mode defaults no-signal, bit0 settable
// - eight halt-quiet pairs give master
// - eight halt pairs give halt
// - eight quiet pairs give quiet
// - sixteen noise events give noise
module line_state_and_injection_regs (
   // clock and reset
   input wire logic clock_i,
   input wire logic sys_rst_i,
   // control bus
   input wire logic bus_wr_i,
   input wire logic bus_rd_i,
   input wire logic [7:0] bus_addr_i,
   input wire logic [7:0] bus_wdata_i,
   output logic [7:0] bus_rdata_o,
   output logic write_reject_flag_o,
   // receiver side
   input wire logic pair_valid_i,
   input wire logic [9:0] pair_i,
   input wire logic noise_event_i,
   input wire logic signal_detect_in_i,
   input wire logic clock_detect_i,
   input wire logic loopback_i,
   input wire logic stop_mode_i,
   input wire logic stop_set_bit0_i,
   // transmitter side
   input wire logic [1:0] inj_mode_i,
   input wire logic [7:0] inj_threshold_i,
   input wire logic [4:0] injection_symbol_first_i,
   input wire logic tx_pair_slot_i,
   input wire logic tx_start_pair_i,
   input wire logic tx_data_pair_i,
   output logic inj_active_o,
   output logic [9:0] inj_pair_o
);
   import line_state_pkg::*;
   // ***********************************************
   // classification of the incoming pair
   // ***********************************************
   pair_if cls ();
   pair_classifier u_cls (
      .pair_valid_i(pair_valid_i),
      .pair_i(pair_i),
      .cls(cls)
   );
   // ***********************************************
   // state
   // ***********************************************
   logic [4:0] sym_reg, sym_next; // second symbol bits
   logic [2:0] code_reg, code_next; // current line-state code
   logic unk_reg, unk_next; // state unknown flag
   logic [2:0] run_kind_reg, run_kind_next; // pattern of the current run
   logic [4:0] run_reg, run_next; // run length, saturating
   logic [4:0] noise_reg, noise_next; // noise event count
   logic [7:0] rdata_reg, rdata_next;
   logic rej_reg, rej_next;
   logic [7:0] inj_cnt_reg, inj_cnt_next; // injection down counter
   logic armed_reg, armed_next; // one-shot armed after start pair
   logic inj_reg, inj_next;
   logic [9:0] ipair_reg, ipair_next;
   logic sig_ok; // signal considered present
   logic [4:0] run_inc;
   // loopback takes its signal internally, so detect is ignored
   assign sig_ok = (loopback_i | signal_detect_in_i) & clock_detect_i;
   assign run_inc = (run_reg == 5'h1f) ? run_reg : run_reg + 5'h01;
   // ***********************************************
   // bus and line state next values
   // ***********************************************
   always_comb begin
      sym_next = sym_reg;
      rej_next = 1'b0;
      rdata_next = rdata_reg;
      code_next = code_reg;
      unk_next = unk_reg;
      run_kind_next = run_kind_reg;
      run_next = run_reg;
      noise_next = noise_reg;
      // register writes; upper bits are simply not stored
      if (bus_wr_i && bus_addr_i == injection_symbol_second_addr) begin
         sym_next = bus_wdata_i[sym_w-1:0];
      end
      // the status register never takes a write
      if (bus_wr_i && bus_addr_i == receive_line_state_addr) begin
         rej_next = 1'b1;
      end
      // receiver tracking
      if (stop_mode_i) begin
         code_next = {no_signal_state[2:1], stop_set_bit0_i};
         unk_next = 1'b0;
         run_next = 5'h00;
         noise_next = 5'h00;
      end else if (!sig_ok) begin
         code_next = no_signal_state;
         unk_next = 1'b0;
         run_next = 5'h00;
         noise_next = 5'h00;
      end else begin
         if (noise_event_i) begin
            noise_next = (noise_reg == 5'h1f) ? noise_reg : noise_reg + 5'h01;
            // compare the saturated count so a wrapped sum never hides the threshold
            if (noise_next >= noise_min) begin
               code_next = noise_state;
               unk_next = 1'b0;
            end
         end
         if (cls.valid) begin
            if (!cls.known) begin
               // unrecognised pair: keep last code, mark unknown unless the code is active
               run_next = 5'h00;
               if (code_reg != active_state || unk_reg) begin
                  unk_next = 1'b1;
               end
            end else begin
               noise_next = 5'h00;
               run_kind_next = cls.kind;
               run_next = (run_kind_reg == cls.kind) ? run_inc : 5'h01;
               // new state replaces the old code in one step
               case (cls.kind)
                  active_state: begin
                     code_next = active_state;
                     unk_next = 1'b0;
                  end
                  idle_state: begin
                     if (run_next >= idle_min) begin
                        code_next = idle_state;
                        unk_next = 1'b0;
                     end else begin
                        unk_next = 1'b1;
                     end
                  end
                  master_state, halt_state, quiet_state: begin
                     if (run_next >= line_min) begin
                        code_next = cls.kind;
                        unk_next = 1'b0;
                     end else begin
                        unk_next = 1'b1;
                     end
                  end
                  default: unk_next = 1'b1;
               endcase
            end
         end
      end
      // read data registered for the flop-driven output
      if (bus_rd_i) begin
         case (bus_addr_i)
            injection_symbol_second_addr: rdata_next = {3'h0, sym_reg};
            receive_line_state_addr: rdata_next = {4'h0, unk_reg, code_reg};
            default: rdata_next = 8'h00;
         endcase
      end
   end
   // ***********************************************
   // injection next values
   // ***********************************************
   always_comb begin
      inj_cnt_next = inj_cnt_reg;
      armed_next = armed_reg;
      inj_next = 1'b0;
      // first symbol then second; each lsb goes out last
      ipair_next = {injection_symbol_first_i, sym_reg};
      case (inj_mode_i)
         inj_one_shot: begin
            if (tx_start_pair_i) begin
               armed_next = 1'b1;
               inj_cnt_next = inj_threshold_i;
               // zero threshold replaces the start pair itself
               if (inj_threshold_i == 8'h00) begin
                  inj_next = 1'b1;
                  armed_next = 1'b0;
               end
            end else if (armed_reg && tx_pair_slot_i) begin
               if (inj_cnt_reg <= 8'h01) begin
                  inj_next = 1'b1;
                  armed_next = 1'b0;
               end else begin
                  inj_cnt_next = inj_cnt_reg - 8'h01;
               end
            end
         end
         inj_periodic: begin
            armed_next = 1'b0;
            if (tx_pair_slot_i) begin
               if (inj_cnt_reg <= 8'h01) begin
                  inj_next = tx_data_pair_i;
                  inj_cnt_next = inj_threshold_i;
               end else begin
                  inj_cnt_next = inj_cnt_reg - 8'h01;
               end
            end
         end
         inj_continuous: begin
            armed_next = 1'b0;
            inj_next = tx_pair_slot_i & tx_data_pair_i;
         end
         default: begin
            armed_next = 1'b0;
            inj_cnt_next = inj_threshold_i;
         end
      endcase
   end
   // ***********************************************
   // registers
   // ***********************************************
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sym_reg <= injection_symbol_second_rst[sym_w-1:0];
         code_reg <= no_signal_state;
         unk_reg <= 1'b1;
         run_kind_reg <= no_signal_state;
         run_reg <= 5'h00;
         noise_reg <= 5'h00;
         rdata_reg <= 8'h00;
         rej_reg <= 1'b0;
         inj_cnt_reg <= 8'h00;
         armed_reg <= 1'b0;
         inj_reg <= 1'b0;
         ipair_reg <= 10'h000;
      end else begin
         sym_reg <= sym_next;
         code_reg <= code_next;
         unk_reg <= unk_next;
         run_kind_reg <= run_kind_next;
         run_reg <= run_next;
         noise_reg <= noise_next;
         rdata_reg <= rdata_next;
         rej_reg <= rej_next;
         inj_cnt_reg <= inj_cnt_next;
         armed_reg <= armed_next;
         inj_reg <= inj_next;
         ipair_reg <= ipair_next;
      end
   end
   assign bus_rdata_o = rdata_reg;
   assign write_reject_flag_o = rej_reg;
   assign inj_active_o = inj_reg;
   assign inj_pair_o = ipair_reg;
endmodule
`default_nettype wire

// *** verilog/pair_classifier.sv ***
`timescale 1ns/1ps
`default_nettype none
// ***********************************************
// pair classifier
// ***********************************************
module pair_classifier (
   // received pair
   input wire logic pair_valid_i,
   input wire logic [9:0] pair_i,
   // classification
   pair_if.src cls
);
   import line_state_pkg::*;
   // pure decode, registered later in the bank
   always_comb begin
      cls.valid = pair_valid_i;
      cls.known = 1'b1;
      case (pair_i)
         pair_start: cls.kind = active_state;
         pair_idle: cls.kind = idle_state;
         pair_halt_quiet: cls.kind = master_state;
         pair_halt: cls.kind = halt_state;
         pair_quiet: cls.kind = quiet_state;
         default: begin
            cls.kind = no_signal_state;
            cls.known = 1'b0;
         end
      endcase
   end
endmodule
`default_nettype wire
